// ---- tei_timer_status.sv ----
// interrupt, status and event action logic of the timer, APB slave
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "tei_defines.svh"
module tei_timer_status (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // counter core events
  input wire logic evtIn,
  input wire logic matchCh0,
  input wire logic matchCh1,
  input wire logic overflowEvt,
  input wire logic updateEvt,
  input wire logic disableEvt,
  input wire logic stopCmd,
  input wire logic captureMode,
  input wire logic waveMode,
  input wire logic mode8,
  input wire logic primary32,
  input wire logic oddUnit,
  input wire logic chBufWr0,
  input wire logic chBufWr1,
  input wire logic perBufWr,
  input wire logic [15:0] countNow,
  // outputs
  output logic irq,
  output logic running,
  output logic copyBuffers,
  output logic restartPulse,
  output logic countStep,
  output logic sync_busy_flags
);
  import tei_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] enable;
  logic [7:0] flags;
  logic [5:3] bufValid;
  logic stopped;
  logic [5:0] evCtrl;
  logic [2:0] ctrl;
  logic [15:0] chValue [0:1];
  logic [15:0] lastEdge;
  logic widthPhase;
  tei_run_type runState;
  tei_run_type next_runState;
  tei_evt_if ev ();

  tei_event_decode u_dec (
    .evtIn(evtIn),
    .evtEnable(evCtrl[`TEI_BIT_EVEN]),
    .sel(tei_action_type'(evCtrl[2:0])),
    .ev(ev)
  );

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  wire logic acc;
  wire logic wr;
  wire logic rd;
  wire logic [7:0] wb;
  wire logic hitEnClr;
  wire logic hitEnSet;
  wire logic hitFlags;
  wire logic hitState;
  wire logic hitEvCtl;
  wire logic hitCtrl;
  wire logic hitCh0;
  wire logic hitCh1;
  wire logic hitAny;
  assign acc = psel & penable & ~pready;
  assign wr = acc & pwrite;
  assign rd = acc & ~pwrite;
  assign wb = pwdata[7:0];
  assign hitEnClr = paddr == `TEI_OFS_ENCLR;
  assign hitEnSet = paddr == `TEI_OFS_ENSET;
  assign hitFlags = paddr == `TEI_OFS_FLAGS;
  assign hitState = paddr == `TEI_OFS_STATE;
  assign hitEvCtl = paddr == `TEI_OFS_EVCTL;
  assign hitCtrl = paddr == `TEI_OFS_CTRL;
  assign hitCh0 = paddr == `TEI_OFS_CH0;
  assign hitCh1 = paddr == `TEI_OFS_CH1;
  assign hitAny = hitEnClr | hitEnSet | hitFlags | hitState | hitEvCtl |
    hitCtrl | hitCh0 | hitCh1;

  wire logic lock;
  wire logic single_pass;
  assign lock = ctrl[`TEI_BIT_LOCK];
  assign single_pass = ctrl[`TEI_BIT_SINGLE_PASS];

  ////////////////////////////////////////////////////////////////////////////
  // captures
  wire logic cap0;
  wire logic cap1;
  wire logic [15:0] span;
  wire logic rdCh0;
  wire logic rdCh1;
  assign span = countNow - lastEdge;
  assign cap0 = captureMode & (ev.stampCap | ev.periodCh0 | ev.periodCh1 |
    ev.widthCap);
  assign cap1 = captureMode & (ev.periodCh0 | ev.periodCh1);
  assign rdCh0 = rd & hitCh0 & captureMode;
  assign rdCh1 = rd & hitCh1 & captureMode;

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      chValue[0] <= 16'h0000;
      chValue[1] <= 16'h0000;
      lastEdge <= 16'h0000;
    end else begin
      if (cap0 || cap1)
        lastEdge <= countNow;
      if (ev.stampCap)
        chValue[0] <= countNow;
      if (ev.widthCap)
        chValue[0] <= span;
      if (ev.periodCh0 && captureMode) begin
        chValue[0] <= span;
        chValue[1] <= countNow - lastEdge - 16'h0001;
      end
      if (ev.periodCh1 && captureMode) begin
        chValue[1] <= span;
        chValue[0] <= countNow - lastEdge - 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // enables and flags
  wire logic [7:0] evtSet;
  wire logic [7:0] clrFlags;
  wire logic [7:0] next_enable;
  wire logic [7:0] next_flags;
  wire logic errHit;
  assign errHit = (cap0 & flags[`TEI_BIT_MC0]) |
    (cap1 & flags[`TEI_BIT_MC1]);
  assign evtSet = {2'b00, matchCh1 | cap1, matchCh0 | cap0, 2'b00,
    errHit, overflowEvt};
  assign clrFlags = ((wr & hitFlags) ? wb : 8'h00) |
    {2'b00, rdCh1, rdCh0, 4'h0};
  // set wins over clear
  assign next_flags = ((flags & ~clrFlags) | evtSet) & `TEI_IRQ_MASK;
  assign next_enable = (((wr & hitEnSet) ? (enable | wb) : enable) &
    ~((wr & hitEnClr) ? wb : 8'h00)) & `TEI_IRQ_MASK;

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      enable <= `TEI_RST_ENABLE;
      flags <= `TEI_RST_FLAGS;
      irq <= 1'b0;
    end else begin
      enable <= next_enable;
      flags <= next_flags;
      irq <= |(next_flags & next_enable);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // buffer valid bits
  wire logic stWr;
  wire logic [5:3] swClr;
  wire logic [5:3] setBv;
  wire logic [5:3] clrBv;
  assign stWr = wr & hitState;
  // zero writes leave status untouched
  assign swClr = (stWr & lock) ? wb[5:3] : 3'b000;
  assign setBv[`TEI_BIT_PBV] = perBufWr & mode8;
  assign setBv[`TEI_BIT_CBV0] = captureMode ? cap0 : chBufWr0;
  assign setBv[`TEI_BIT_CBV1] = captureMode ? cap1 : chBufWr1;
  assign clrBv[`TEI_BIT_PBV] = (updateEvt & ~lock) | swClr[3];
  assign clrBv[`TEI_BIT_CBV0] = captureMode ? rdCh0 :
    ((updateEvt & ~lock) | swClr[4]);
  assign clrBv[`TEI_BIT_CBV1] = captureMode ? rdCh1 :
    ((updateEvt & ~lock) | swClr[5]);

  always_ff @(posedge ref_clk) begin
    if (!rstn)
      bufValid <= 3'b000;
    else
      bufValid <= ((bufValid & ~clrBv) | setBv) &
        {2'b11, mode8};
  end

  ////////////////////////////////////////////////////////////////////////////
  // run state
  wire logic wrapStop;
  assign wrapStop = overflowEvt & single_pass;
  always_comb begin
    next_runState = runState;
    case (runState)
      TEI_RUN_STOP:
        if (ev.startAny || ev.startOnly)
          next_runState = TEI_RUN_CNT;
      TEI_RUN_CNT:
        if (disableEvt || stopCmd || wrapStop)
          next_runState = TEI_RUN_STOP;
        else if (ev.startAny)
          next_runState = TEI_RUN_WAIT;
      TEI_RUN_WAIT:
        next_runState = (disableEvt || stopCmd || wrapStop) ? TEI_RUN_STOP :
          TEI_RUN_CNT;
      default:
        next_runState = TEI_RUN_STOP;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      runState <= TEI_RUN_STOP;
      stopped <= `TEI_RST_STOP;
      running <= 1'b0;
      restartPulse <= 1'b0;
      countStep <= 1'b0;
      copyBuffers <= 1'b0;
    end else begin
      runState <= next_runState;
      stopped <= next_runState == TEI_RUN_STOP;
      running <= next_runState != TEI_RUN_STOP;
      restartPulse <= ev.startAny | (ev.startOnly & (runState ==
        TEI_RUN_STOP));
      countStep <= ev.countEvt & ~waveMode;
      copyBuffers <= updateEvt & ~lock;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control registers and status sync busy
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      evCtrl <= 6'h00;
      ctrl <= 3'h0;
      sync_busy_flags <= 1'b0;
    end else begin
      if (wr && hitEvCtl)
        evCtrl <= wb[5:0];
      if (wr && hitCtrl)
        ctrl <= wb[2:0];
      sync_busy_flags <= stWr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux and handshake
  wire logic [7:0] stateView;
  wire logic [31:0] rdMux;
  assign stateView = {2'b00, bufValid, 1'b0, primary32 & oddUnit,
    stopped};
  assign rdMux = (hitEnClr | hitEnSet) ? {24'h0, enable} :
    hitFlags ? {24'h0, flags} :
    hitState ? {24'h0, stateView} :
    hitEvCtl ? {26'h0, evCtrl} :
    hitCtrl ? {29'h0, ctrl} :
    hitCh0 ? {16'h0, chValue[0]} :
    hitCh1 ? {16'h0, chValue[1]} : 32'h0;

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= acc;
      pslverr <= acc & ~hitAny;
      if (rd)
        prdata <= rdMux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_enable_clear: assert property (@(posedge ref_clk)
    disable iff (!rstn)
    wr && hitEnClr |=> (enable & $past(wb) & `TEI_IRQ_MASK) == 8'h00)
    else $error("enable not cleared");
  a_enable_set: assert property (@(posedge ref_clk)
    disable iff (!rstn)
    wr && hitEnSet |=> ((enable & $past(wb)) == ($past(wb) & `TEI_IRQ_MASK)))
    else $error("enable not set");
  a_flag_sets: assert property (@(posedge ref_clk)
    disable iff (!rstn)
    overflowEvt |=> flags[`TEI_BIT_OVF])
    else $error("overflow flag missed");
  a_flag_clear: assert property (@(posedge ref_clk)
    disable iff (!rstn)
    wr && hitFlags && wb[`TEI_BIT_MC0] && !matchCh0 && !cap0
    |=> !flags[`TEI_BIT_MC0])
    else $error("match flag not cleared");
  a_error_raise: assert property (@(posedge ref_clk)
    disable iff (!rstn)
    cap0 && flags[`TEI_BIT_MC0] |=> flags[`TEI_BIT_ERR])
    else $error("error flag missed");
  a_irq_line: assert property (@(posedge ref_clk)
    disable iff (!rstn)
    ##1 irq == |(flags & enable))
    else $error("irq mismatch");
  a_stop_single_pass: assert property (@(posedge ref_clk)
    disable iff (!rstn)
    running && wrapStop |=> stopped && !running)
    else $error("single pass did not stop");
  a_lock_copy: assert property (@(posedge ref_clk)
    disable iff (!rstn)
    lock |=> !copyBuffers)
    else $error("copy while locked");
  a_event_gate: assert property (@(posedge ref_clk)
    disable iff (!rstn)
    !evCtrl[`TEI_BIT_EVEN] && stopped |=> stopped || $past(disableEvt))
    else $error("event acted while disabled");
  a_pready_once: assert property (@(posedge ref_clk) disable iff (!rstn)
    pready |=> !pready)
    else $error("pready held");
  c_capture: cover property (@(posedge ref_clk) disable iff (!rstn) cap1);
  c_irq: cover property (@(posedge ref_clk) disable iff (!rstn) irq);
  c_restart: cover property (@(posedge ref_clk) disable iff (!rstn)
    restartPulse);
  c_one_shot: cover property (@(posedge ref_clk) disable iff (!rstn)
    running && wrapStop);
endmodule : tei_timer_status

// ---- tei_defines.svh ----
// register offsets, field positions and reset values of the timer status block
`ifndef TEI_DEFINES_SVH
`define TEI_DEFINES_SVH
`define TEI_OFS_ENCLR 8'h08
`define TEI_OFS_ENSET 8'h09
`define TEI_OFS_FLAGS 8'h0A
`define TEI_OFS_STATE 8'h0B
`define TEI_OFS_EVCTL 8'h0C
`define TEI_OFS_CTRL 8'h0D
`define TEI_OFS_CH0 8'h10
`define TEI_OFS_CH1 8'h14
`define TEI_BIT_OVF 0
`define TEI_BIT_ERR 1
`define TEI_BIT_MC0 4
`define TEI_BIT_MC1 5
`define TEI_BIT_STOP 0
`define TEI_BIT_SECU 1
`define TEI_BIT_PBV 3
`define TEI_BIT_CBV0 4
`define TEI_BIT_CBV1 5
`define TEI_BIT_EVEN 5
`define TEI_BIT_SINGLE_PASS 2
`define TEI_BIT_LOCK 1
`define TEI_IRQ_MASK 8'h33
`define TEI_RST_ENABLE 8'h00
`define TEI_RST_FLAGS 8'h00
`define TEI_RST_STATE 8'h01
`define TEI_RST_STOP 1'b1
`endif

// ---- tei_pkg.sv ----
// types of the timer status block
package tei_pkg;
  typedef enum logic [2:0] {
    TEI_ACT_OFF = 3'h0,
    TEI_ACT_RETRIG = 3'h1,
    TEI_ACT_COUNT = 3'h2,
    TEI_ACT_START = 3'h3,
    TEI_ACT_STAMP = 3'h4,
    TEI_ACT_PPW = 3'h5,
    TEI_ACT_PWP = 3'h6,
    TEI_ACT_PW = 3'h7
  } tei_action_type;
  typedef enum logic [2:0] {
    TEI_RUN_STOP = 3'b001,
    TEI_RUN_CNT = 3'b010,
    TEI_RUN_WAIT = 3'b100
  } tei_run_type;
endpackage : tei_pkg

// ---- tei_evt_if.sv ----
// decoded event action strobes between decoder and core
`timescale 1ns/1ps
interface tei_evt_if;
  logic startAny;
  logic startOnly;
  logic stampCap;
  logic periodCh0;
  logic periodCh1;
  logic widthCap;
  logic countEvt;
  modport dec (output startAny, startOnly, stampCap, periodCh0, periodCh1,
    widthCap, countEvt);
  modport core (input startAny, startOnly, stampCap, periodCh0, periodCh1,
    widthCap, countEvt);
endinterface : tei_evt_if

// ---- tei_event_decode.sv ----
// event action selector decoder
`timescale 1ns/1ps
module tei_event_decode (
  // selection
  input wire logic evtIn,
  input wire logic evtEnable,
  input wire tei_pkg::tei_action_type sel,
  // decoded strobes
  tei_evt_if.dec ev
);
  import tei_pkg::*;
  wire logic go;
  assign go = evtIn & evtEnable;
  assign ev.startAny = go & (sel == TEI_ACT_RETRIG);
  assign ev.startOnly = go & (sel == TEI_ACT_START);
  assign ev.stampCap = go & (sel == TEI_ACT_STAMP);
  assign ev.periodCh0 = go & (sel == TEI_ACT_PPW);
  assign ev.periodCh1 = go & (sel == TEI_ACT_PWP);
  assign ev.widthCap = go & (sel == TEI_ACT_PW);
  assign ev.countEvt = go & (sel == TEI_ACT_COUNT);
endmodule : tei_event_decode

// ---- tei_timer_status_tb.sv ----
// self-checking testbench of the timer status block
`timescale 1ns/1ps
`include "tei_defines.svh"
module tei_timer_status_tb;
  logic ref_clk, rstn, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [10:0] pv;
  logic [4:0] lv;
  logic [3:0] po;
  logic [15:0] cnt;
  logic bz, running, copyBuffers, restartPulse, countStep, sync_busy_flags;
  int errorCnt, nTests, cyc;
  ////////////////////////////////////////////////////////////////////////
  tei_timer_status i_dut (.ref_clk(ref_clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .evtIn(pv[0]),
    .matchCh0(pv[1]), .matchCh1(pv[2]), .overflowEvt(pv[3]),
    .updateEvt(pv[4]), .disableEvt(pv[5]), .stopCmd(pv[6]),
    .captureMode(lv[0]), .waveMode(lv[1]), .mode8(lv[2]),
    .primary32(lv[3]), .oddUnit(lv[4]), .chBufWr0(pv[7]),
    .chBufWr1(pv[8]), .perBufWr(pv[9]), .countNow(cnt),
    .irq(irq), .running(running), .copyBuffers(copyBuffers),
    .restartPulse(restartPulse), .countStep(countStep),
    .sync_busy_flags(sync_busy_flags));
  ////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic finalReport;
    if (errorCnt == 0 && nTests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finalReport
  initial begin
    cyc = 0;
    forever begin
      @(posedge ref_clk);
      cyc++;
      if (cyc > 5000) begin
        errorCnt++;
        finalReport();
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nTests++;
    if (got !== exp) begin
      errorCnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    while (a == `TEI_OFS_STATE && sync_busy_flags === 1'b1)
      @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rdv = prdata;
    bz = sync_busy_flags;
    chk({31'h0, pslverr}, {31'h0, a == 8'h40});
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdv, exp);
  endtask : rd
  task automatic pulse(input int k);
    pv <= 11'h1 << k;
    @(posedge ref_clk);
    pv <= 11'h000;
    @(posedge ref_clk);
    po = {countStep, restartPulse, copyBuffers, running};
    @(posedge ref_clk);
  endtask : pulse
  ////////////////////////////////////////////////////////////////////////
  initial begin
    errorCnt = 0;
    nTests = 0;
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pv = 11'h000;
    lv = 5'h00;
    cnt = 16'h0123;
    repeat (10) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    rd(`TEI_OFS_STATE, 32'h01);
    rd(`TEI_OFS_FLAGS, 32'h00);
    rd(`TEI_OFS_ENSET, 32'h00);
    wr(`TEI_OFS_ENSET, 32'hFF);
    rd(`TEI_OFS_ENSET, 32'h33);
    rd(`TEI_OFS_ENCLR, 32'h33);
    wr(`TEI_OFS_ENCLR, 32'h11);
    rd(`TEI_OFS_ENSET, 32'h22);
    pulse(3);
    rd(`TEI_OFS_FLAGS, 32'h01);
    chk({31'h0, irq}, 32'h0);
    wr(`TEI_OFS_ENSET, 32'h01);
    chk({31'h0, irq}, 32'h1);
    wr(`TEI_OFS_FLAGS, 32'h00);
    rd(`TEI_OFS_FLAGS, 32'h01);
    wr(`TEI_OFS_FLAGS, 32'h01);
    rd(`TEI_OFS_FLAGS, 32'h00);
    chk({31'h0, irq}, 32'h0);
    pulse(2);
    rd(`TEI_OFS_FLAGS, 32'h20);
    chk({31'h0, irq}, 32'h1);
    wr(`TEI_OFS_FLAGS, 32'h20);
    rd(`TEI_OFS_FLAGS, 32'h00);
    rd(8'h40, 32'h0);
    lv <= 5'h01;
    wr(`TEI_OFS_EVCTL, 32'h04);
    pulse(0);
    rd(`TEI_OFS_FLAGS, 32'h00);
    wr(`TEI_OFS_EVCTL, 32'h24);
    pulse(0);
    rd(`TEI_OFS_FLAGS, 32'h10);
    pulse(0);
    rd(`TEI_OFS_FLAGS, 32'h12);
    rd(`TEI_OFS_CH0, 32'h0123);
    rd(`TEI_OFS_FLAGS, 32'h02);
    wr(`TEI_OFS_FLAGS, 32'h02);
    rd(`TEI_OFS_FLAGS, 32'h00);
    lv <= 5'h00;
    wr(`TEI_OFS_EVCTL, 32'h21);
    pulse(0);
    chk({28'h0, po}, 32'h5);
    rd(`TEI_OFS_STATE, 32'h00);
    pulse(6);
    chk({28'h0, po}, 32'h0);
    rd(`TEI_OFS_STATE, 32'h01);
    pulse(7);
    rd(`TEI_OFS_STATE, 32'h11);
    wr(`TEI_OFS_STATE, 32'h00);
    chk({31'h0, bz}, 32'h1);
    rd(`TEI_OFS_STATE, 32'h11);
    pulse(4);
    chk({28'h0, po}, 32'h2);
    rd(`TEI_OFS_STATE, 32'h01);
    lv <= 5'h04;
    pulse(9);
    rd(`TEI_OFS_STATE, 32'h09);
    lv <= 5'h00;
    rd(`TEI_OFS_STATE, 32'h01);
    pulse(4);
    lv <= 5'h18;
    rd(`TEI_OFS_STATE, 32'h03);
    lv <= 5'h00;
    wr(`TEI_OFS_EVCTL, 32'h23);
    pulse(0);
    chk({28'h0, po}, 32'h5);
    pulse(0);
    chk({28'h0, po}, 32'h1);
    wr(`TEI_OFS_CTRL, 32'h04);
    pulse(3);
    chk({28'h0, po}, 32'h0);
    rd(`TEI_OFS_STATE, 32'h01);
    wr(`TEI_OFS_FLAGS, 32'h01);
    wr(`TEI_OFS_EVCTL, 32'h22);
    pulse(0);
    chk({28'h0, po}, 32'h8);
    wr(`TEI_OFS_CTRL, 32'h02);
    pulse(7);
    pulse(4);
    chk({28'h0, po}, 32'h0);
    rd(`TEI_OFS_STATE, 32'h11);
    wr(`TEI_OFS_STATE, 32'h10);
    wr(`TEI_OFS_STATE, 32'h10);
    rd(`TEI_OFS_STATE, 32'h01);
    lv <= 5'h01;
    cnt <= 16'h0200;
    wr(`TEI_OFS_EVCTL, 32'h25);
    pulse(0);
    rd(`TEI_OFS_FLAGS, 32'h30);
    rd(`TEI_OFS_CH0, 32'h00DD);
    rd(`TEI_OFS_CH1, 32'h00DC);
    cnt <= 16'h0300;
    wr(`TEI_OFS_EVCTL, 32'h26);
    pulse(0);
    rd(`TEI_OFS_CH0, 32'h00FF);
    rd(`TEI_OFS_CH1, 32'h0100);
    cnt <= 16'h0350;
    wr(`TEI_OFS_EVCTL, 32'h27);
    pulse(0);
    rd(`TEI_OFS_CH0, 32'h0050);
    rd(`TEI_OFS_FLAGS, 32'h00);
    finalReport();
  end
endmodule : tei_timer_status_tb
